// ==== hdl/cag_pkg.sv ====
// shared types and constants of the address generation block
// assumes a 10-bit instruction word and a 14-bit program counter
package cag_pkg;

  localparam int unsigned WORD_W   = 10;
  localparam int unsigned RAM_AW   = 10;
  localparam int unsigned PC_W     = 14;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned BANK_W   = 2;
  localparam int unsigned PAGE_W   = 8;
  localparam int unsigned ZPG_W    = 6;
  localparam int unsigned LONG_HI  = 4;
  localparam int unsigned ACC_FLAG = 8;
  localparam int unsigned PORT_FLAG = 9;

  localparam logic [RAM_AW-1:0] MEMREG_BASE = 10'h040;
  localparam logic [RAM_AW-1:0] MEMREG_LAST = 10'h04F;
  localparam logic [PC_W-1:0]   ZPG_LAST    = 14'h003F;
  localparam logic [NIB_W-1:0]  NIB_RST     = 4'h0;
  localparam logic [RAM_AW-1:0] RAM_RST     = 10'h000;
  localparam logic [PC_W-1:0]   PC_RST      = 14'h0000;

  typedef enum logic [3:0] {
    CAG_OP_NONE       = 4'h0,
    CAG_OP_RAM_IND    = 4'h1,
    CAG_OP_RAM_DIRECT = 4'h2,
    CAG_OP_MEMREG     = 4'h3,
    CAG_OP_LONG_JUMP  = 4'h4,
    CAG_OP_LONG_BR    = 4'h5,
    CAG_OP_FAR_CALL   = 4'h6,
    CAG_OP_IN_PAGE    = 4'h7,
    CAG_OP_ZERO_CALL  = 4'h8,
    CAG_OP_TABLE_JUMP = 4'h9,
    CAG_OP_TABLE_LOAD = 4'hA
  } cag_op_e;

  typedef enum logic [2:0] {
    CAG_ST_IDLE  = 3'b001,
    CAG_ST_FETCH = 3'b010,
    CAG_ST_TAKE  = 3'b100
  } cag_state_e;

  typedef struct packed {
    logic              valid;
    cag_op_e           op;
    logic [WORD_W-1:0] op_word;
    logic [WORD_W-1:0] arg_word;
  } cag_req_s;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [NIB_W-1:0]  mid;
    logic [NIB_W-1:0]  low;
  } cag_ptr_s;

endpackage

// ==== hdl/cag_table_sink.sv ====
// table word sink: steers a fetched table word to accumulator pair and port pair
// assumes rom_word is valid in the cycle take is high
`timescale 1ns/10ps
`default_nettype none
module cag_table_sink
  import cag_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              take,
  input  wire logic [WORD_W-1:0] rom_word,
  output logic                   acc_wr_q,
  output logic [NIB_W-1:0]       acc_val_q,
  output logic [NIB_W-1:0]       aux_val_q,
  output logic                   port_wr_q,
  output logic [NIB_W-1:0]       port_out_one_q,
  output logic [NIB_W-1:0]       port_out_two_q
);

  logic             acc_wr_d;
  logic [NIB_W-1:0] acc_val_d;
  logic [NIB_W-1:0] aux_val_d;
  logic             port_wr_d;
  logic [NIB_W-1:0] port_out_one_d;
  logic [NIB_W-1:0] port_out_two_d;

  // both flags set writes both pairs in the same edge
  always_comb begin
    acc_wr_d       = take && rom_word[ACC_FLAG];
    port_wr_d      = take && rom_word[PORT_FLAG];
    acc_val_d      = acc_val_q;
    aux_val_d      = aux_val_q;
    port_out_one_d = port_out_one_q;
    port_out_two_d = port_out_two_q;
    if (acc_wr_d) begin
      acc_val_d = rom_word[NIB_W-1:0];
      aux_val_d = rom_word[2*NIB_W-1:NIB_W];
    end
    if (port_wr_d) begin
      port_out_one_d = rom_word[NIB_W-1:0];
      port_out_two_d = rom_word[2*NIB_W-1:NIB_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_wr_q       <= 1'b0;
      acc_val_q      <= NIB_RST;
      aux_val_q      <= NIB_RST;
      port_wr_q      <= 1'b0;
      port_out_one_q <= NIB_RST;
      port_out_two_q <= NIB_RST;
    end else begin
      acc_wr_q       <= acc_wr_d;
      acc_val_q      <= acc_val_d;
      aux_val_q      <= aux_val_d;
      port_wr_q      <= port_wr_d;
      port_out_one_q <= port_out_one_d;
      port_out_two_q <= port_out_two_d;
    end
  end

  acc_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && rom_word[ACC_FLAG] |=> acc_wr_q && acc_val_q == $past(rom_word[3:0])
      && aux_val_q == $past(rom_word[7:4]))
    else $error("accumulator pair not loaded from table word");

  port_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && rom_word[PORT_FLAG] |=> port_wr_q && port_out_one_q == $past(rom_word[3:0])
      && port_out_two_q == $past(rom_word[7:4]))
    else $error("port pair not loaded from table word");

  port_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(take && rom_word[PORT_FLAG]) |=> !port_wr_q && $stable(port_out_one_q)
      && $stable(port_out_two_q))
    else $error("port register changed without flag");

endmodule
`default_nettype wire

// ==== hdl/cag_top.sv ====
// address generation for the 4-bit core: ram addresses, rom branch targets, table load
// assumes the sequencer holds req one cycle, waits while busy_q, and that
// rom_data answers rom_rd_q one cycle later; pc_next is the incremented pc
`timescale 1ns/10ps
`default_nettype none
module cag_top
  import cag_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire cag_req_s          req,
  input  wire cag_ptr_s          ptr,
  input  wire logic [NIB_W-1:0]  acc,
  input  wire logic [NIB_W-1:0]  aux,
  input  wire logic [PC_W-1:0]   pc_next,
  input  wire logic [WORD_W-1:0] rom_data,
  output logic [RAM_AW-1:0]      ram_addr_q,
  output logic                   ram_vld_q,
  output logic [PC_W-1:0]        pc_target_q,
  output logic                   pc_load_q,
  output logic [PC_W-1:0]        rom_addr_q,
  output logic                   rom_rd_q,
  output logic                   busy_q,
  output logic                   acc_wr_q,
  output logic [NIB_W-1:0]       acc_val_q,
  output logic [NIB_W-1:0]       aux_val_q,
  output logic                   port_wr_q,
  output logic [NIB_W-1:0]       port_out_one_q,
  output logic [NIB_W-1:0]       port_out_two_q
);

  cag_state_e        state_q;
  cag_state_e        state_d;
  logic [RAM_AW-1:0] ram_addr_d;
  logic              ram_vld_d;
  logic [PC_W-1:0]   pc_target_d;
  logic              pc_load_d;
  logic [PC_W-1:0]   rom_addr_d;
  logic              rom_rd_d;
  logic              busy_d;
  logic [PC_W-1:0]   table_addr;
  logic              take;
  logic              issue;

  // requests are only looked at while idle; the sequencer is stalled by busy_q
  assign issue = req.valid && (state_q == CAG_ST_IDLE);

  // upper pc bits stay zero: the table area is the low 4k words
  assign table_addr = {2'b00, req.op_word[NIB_W-1:0], aux, acc};

  always_comb begin
    state_d     = state_q;
    ram_addr_d  = ram_addr_q;
    ram_vld_d   = 1'b0;
    pc_target_d = pc_target_q;
    pc_load_d   = 1'b0;
    rom_addr_d  = rom_addr_q;
    rom_rd_d    = 1'b0;
    busy_d      = 1'b0;
    case (state_q)
      CAG_ST_IDLE: begin
        if (issue) begin
          case (req.op)
            CAG_OP_RAM_IND: begin
              ram_addr_d = {ptr.bank, ptr.mid, ptr.low};
              ram_vld_d  = 1'b1;
            end
            CAG_OP_RAM_DIRECT: begin
              ram_addr_d = req.arg_word;
              ram_vld_d  = 1'b1;
            end
            CAG_OP_MEMREG: begin
              ram_addr_d = MEMREG_BASE | {6'h00, req.op_word[NIB_W-1:0]};
              ram_vld_d  = 1'b1;
            end
            CAG_OP_LONG_JUMP, CAG_OP_LONG_BR, CAG_OP_FAR_CALL: begin
              pc_target_d = {req.op_word[LONG_HI-1:0], req.arg_word};
              pc_load_d   = 1'b1;
            end
            CAG_OP_IN_PAGE: begin
              // page taken from the incremented pc, so the last word of a page
              // branches into the following one
              pc_target_d = {pc_next[PC_W-1:PAGE_W], req.op_word[PAGE_W-1:0]};
              pc_load_d   = 1'b1;
            end
            CAG_OP_ZERO_CALL: begin
              pc_target_d = {8'h00, req.op_word[ZPG_W-1:0]};
              pc_load_d   = 1'b1;
            end
            CAG_OP_TABLE_JUMP: begin
              pc_target_d = table_addr;
              pc_load_d   = 1'b1;
            end
            CAG_OP_TABLE_LOAD: begin
              rom_addr_d = table_addr;
              rom_rd_d   = 1'b1;
              busy_d     = 1'b1;
              state_d    = CAG_ST_FETCH;
            end
            default: begin
              state_d = CAG_ST_IDLE;
            end
          endcase
        end
      end
      CAG_ST_FETCH: begin
        busy_d  = 1'b1;
        state_d = CAG_ST_TAKE;
      end
      CAG_ST_TAKE: begin
        // pc_load stays low across the whole table load
        state_d = CAG_ST_IDLE;
      end
      default: begin
        state_d = CAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q     <= CAG_ST_IDLE;
      ram_addr_q  <= RAM_RST;
      ram_vld_q   <= 1'b0;
      pc_target_q <= PC_RST;
      pc_load_q   <= 1'b0;
      rom_addr_q  <= PC_RST;
      rom_rd_q    <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      ram_addr_q  <= ram_addr_d;
      ram_vld_q   <= ram_vld_d;
      pc_target_q <= pc_target_d;
      pc_load_q   <= pc_load_d;
      rom_addr_q  <= rom_addr_d;
      rom_rd_q    <= rom_rd_d;
      busy_q      <= busy_d;
    end
  end

  // rom word is data here: it goes to the sink, never to the decoder
  assign take = (state_q == CAG_ST_TAKE);

  cag_table_sink u_sink (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .take           (take),
    .rom_word       (rom_data),
    .acc_wr_q       (acc_wr_q),
    .acc_val_q      (acc_val_q),
    .aux_val_q      (aux_val_q),
    .port_wr_q      (port_wr_q),
    .port_out_one_q (port_out_one_q),
    .port_out_two_q (port_out_two_q)
  );

  ram_indirect_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_RAM_IND |=> ram_vld_q
      && ram_addr_q[9:8] == $past(ptr.bank) && ram_addr_q[7:4] == $past(ptr.mid)
      && ram_addr_q[3:0] == $past(ptr.low))
    else $error("indirect ram address wrong");

  ram_direct_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_RAM_DIRECT |=> ram_vld_q && ram_addr_q == $past(req.arg_word))
    else $error("direct ram address wrong");

  memreg_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_MEMREG |=> ram_vld_q
      && ram_addr_q >= MEMREG_BASE && ram_addr_q <= MEMREG_LAST
      && ram_addr_q[3:0] == $past(req.op_word[3:0]))
    else $error("memory register address out of range");

  long_target_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op inside {CAG_OP_LONG_JUMP, CAG_OP_LONG_BR, CAG_OP_FAR_CALL}
      |=> pc_load_q && pc_target_q == {$past(req.op_word[3:0]), $past(req.arg_word)})
    else $error("long target wrong");

  in_page_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_IN_PAGE |=> pc_load_q
      && pc_target_q[13:8] == $past(pc_next[13:8])
      && pc_target_q[7:0] == $past(req.op_word[7:0]))
    else $error("in-page target left the page");

  page_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_IN_PAGE && pc_next[7:0] == 8'h00
      |=> pc_target_q[13:8] == $past(pc_next[13:8]))
    else $error("page boundary jump did not reach next page");

  zero_call_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_ZERO_CALL |=> pc_load_q && pc_target_q <= ZPG_LAST
      && pc_target_q[5:0] == $past(req.op_word[5:0]))
    else $error("zero-page call target wrong");

  table_jump_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_TABLE_JUMP
      |=> pc_load_q && pc_target_q == $past(table_addr))
    else $error("table jump target wrong");

  table_fetch_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_TABLE_LOAD
      |=> rom_rd_q && busy_q && rom_addr_q == $past(table_addr) ##1 !rom_rd_q && take)
    else $error("table fetch sequence wrong");

  table_no_pc_a: assert property (@(posedge clk_sys) disable iff (reset)
    issue && req.op == CAG_OP_TABLE_LOAD |=> !pc_load_q [*3])
    else $error("table load touched the pc");

endmodule
`default_nettype wire

// ==== verif/cag_top_tb.sv ====
// self-checking bench for cag_top: random and corner requests of every op
// assumes answers one cycle after a request and a table load result three cycles after
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cag_top_tb;
  import cag_pkg::*;
  logic              clk_sys;
  logic              reset;
  cag_req_s          req;
  cag_ptr_s          ptr;
  logic [NIB_W-1:0]  acc, aux, e_acc, e_aux, e_p1, e_p2;
  logic [PC_W-1:0]   pc_next, pc_target_q, rom_addr_q;
  logic [WORD_W-1:0] rom_data;
  logic [RAM_AW-1:0] ram_addr_q;
  logic              ram_vld_q, pc_load_q, rom_rd_q, busy_q, acc_wr_q, port_wr_q;
  logic [NIB_W-1:0]  acc_val_q, aux_val_q, port_out_one_q, port_out_two_q;
  int                num_errors = 0;
  int                compares = 0;

  cag_top i_dut (.clk_sys(clk_sys), .reset(reset), .req(req), .ptr(ptr), .acc(acc),
    .aux(aux), .pc_next(pc_next), .rom_data(rom_data), .ram_addr_q(ram_addr_q),
    .ram_vld_q(ram_vld_q), .pc_target_q(pc_target_q), .pc_load_q(pc_load_q),
    .rom_addr_q(rom_addr_q), .rom_rd_q(rom_rd_q), .busy_q(busy_q), .acc_wr_q(acc_wr_q),
    .acc_val_q(acc_val_q), .aux_val_q(aux_val_q), .port_wr_q(port_wr_q),
    .port_out_one_q(port_out_one_q), .port_out_two_q(port_out_two_q));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [PC_W-1:0] exp_tgt(input cag_op_e op, input logic [WORD_W-1:0] ow,
                                               input logic [WORD_W-1:0] aw);
    case (op)
      CAG_OP_IN_PAGE:   return {pc_next[PC_W-1:PAGE_W], ow[7:0]};
      CAG_OP_ZERO_CALL: return {8'h00, ow[5:0]};
      CAG_OP_TABLE_JUMP, CAG_OP_TABLE_LOAD: return {2'b00, ow[3:0], aux, acc};
      default:          return {ow[3:0], aw};
    endcase
  endfunction

  function automatic logic [RAM_AW-1:0] exp_ram(input cag_op_e op, input logic [WORD_W-1:0] ow,
                                                input logic [WORD_W-1:0] aw);
    case (op)
      CAG_OP_RAM_IND:    return {ptr.bank, ptr.mid, ptr.low};
      CAG_OP_RAM_DIRECT: return aw;
      default:           return MEMREG_BASE | {6'h00, ow[3:0]};
    endcase
  endfunction

  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one request with fresh pointer, acc and aux; w is the table word, intr adds
  // requests during the fetch and take cycles that must be dropped
  task automatic run_op(input cag_op_e op, input logic [WORD_W-1:0] ow, input logic [WORD_W-1:0] aw,
                        input logic [PC_W-1:0] pcn, input logic [WORD_W-1:0] w, input logic intr);
    @(posedge clk_sys);
    req     <= '{valid: 1'b1, op: op, op_word: ow, arg_word: aw};
    ptr     <= cag_ptr_s'(10'($urandom));
    acc     <= 4'($urandom);
    aux     <= 4'($urandom);
    pc_next <= pcn;
    @(posedge clk_sys);
    req.valid <= intr;
    req.op    <= CAG_OP_RAM_IND;
    rom_data  <= ~w;
    #1;
    if (op inside {CAG_OP_RAM_IND, CAG_OP_RAM_DIRECT, CAG_OP_MEMREG}) begin
      `CHK(ram_vld_q, 1'b1)
      `CHK(ram_addr_q, exp_ram(op, ow, aw))
      `CHK(pc_load_q, 1'b0)
    end else if (op == CAG_OP_NONE || op > CAG_OP_TABLE_LOAD) begin
      // no-op and unused codes must leave ram_vld_q, pc_load_q, rom_rd_q and busy_q low
      `CHK({ram_vld_q, pc_load_q, rom_rd_q, busy_q}, 4'h0)
    end else if (op != CAG_OP_TABLE_LOAD) begin
      `CHK(pc_load_q, 1'b1)
      `CHK(pc_target_q, exp_tgt(op, ow, aw))
      `CHK(ram_vld_q, 1'b0)
    end else begin
      `CHK(rom_rd_q, 1'b1)
      `CHK(rom_addr_q, exp_tgt(op, ow, aw))
      `CHK(busy_q, 1'b1)
      `CHK(pc_load_q, 1'b0)
      @(posedge clk_sys);
      req.valid <= intr;
      rom_data  <= w;
      #1;
      `CHK({rom_rd_q, busy_q, ram_vld_q, pc_load_q}, 4'h4)
      @(posedge clk_sys);
      req.valid <= 1'b0;
      rom_data  <= ~w;
      #1;
      if (w[ACC_FLAG]) begin
        e_acc = w[3:0];
        e_aux = w[7:4];
      end
      if (w[PORT_FLAG]) begin
        e_p1 = w[3:0];
        e_p2 = w[7:4];
      end
      `CHK(acc_wr_q, w[ACC_FLAG])
      `CHK(port_wr_q, w[PORT_FLAG])
      `CHK({acc_val_q, aux_val_q}, {e_acc, e_aux})
      `CHK({port_out_one_q, port_out_two_q}, {e_p1, e_p2})
      `CHK({busy_q, pc_load_q, ram_vld_q}, 3'h0)
    end
  endtask

  initial begin
    #400_000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    cag_op_e op;
    logic [WORD_W-1:0] w;
    reset    = 1'b1;
    req      = '0;
    ptr      = '0;
    acc      = 4'h0;
    aux      = 4'h0;
    pc_next  = 14'h0000;
    rom_data = 10'h000;
    e_acc = 4'h0;
    e_aux = 4'h0;
    e_p1  = 4'h0;
    e_p2  = 4'h0;
    void'($urandom(32'h29C8));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK({ram_addr_q, ram_vld_q, pc_target_q, pc_load_q, rom_addr_q, rom_rd_q}, '0)
    `CHK({busy_q, acc_wr_q, port_wr_q, acc_val_q, aux_val_q, port_out_one_q, port_out_two_q}, '0)
    // extremes of every field for the no-op and each op up to table jump, then the last word of a page
    for (int i = 0; i <= 9; i++) begin
      op = cag_op_e'(4'(i));
      run_op(op, 10'h3FF, 10'h3FF, 14'h3FFF, 10'h000, 1'b0);
      run_op(op, 10'h000, 10'h000, 14'h0000, 10'h000, 1'b0);
    end
    // in-page jump sitting at 0x2FF: pc already moved to the next page
    run_op(CAG_OP_IN_PAGE, 10'h0AB, 10'h000, 14'h0300, 10'h000, 1'b0);
    // all four flag combinations, the last with a request that must be dropped
    for (int k = 0; k < 4; k++) begin
      w = {2'(k), 8'($urandom)};
      run_op(CAG_OP_TABLE_LOAD, 10'($urandom), 10'h000, 14'($urandom), w, k == 3);
    end
    // mid-run reset must clear the loaded table values and every strobe
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK({ram_addr_q, ram_vld_q, pc_target_q, pc_load_q, rom_addr_q, rom_rd_q}, '0)
    `CHK({busy_q, acc_wr_q, port_wr_q, acc_val_q, aux_val_q, port_out_one_q, port_out_two_q}, '0)
    e_acc = 4'h0;
    e_aux = 4'h0;
    e_p1  = 4'h0;
    e_p2  = 4'h0;
    // unused op codes are drawn as well and must do nothing
    for (int n = 0; n < 300; n++) begin
      op = cag_op_e'(4'($urandom_range(15, 0)));
      run_op(op, 10'($urandom), 10'($urandom), 14'($urandom), 10'($urandom), 1'b0);
    end
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
